/* File: sfp_pkg.sv */
package sfp_pkg;

    localparam int             PTR_W         = 22;
    localparam int             CMD_W         = 4;
    localparam int             PAY_W         = 16;
    localparam int             BYTE_W        = 8;
    localparam int             WBUF_BYTES    = 64;
    localparam int             EBUF_BYTES    = 64;
    localparam int             CODE_SEL_BIT  = 7;
    localparam int             CFG_SEL_BIT   = 6;

    localparam logic [3:0]     CMD_CORE      = 4'h0;
    localparam logic [3:0]     CMD_RD_INC    = 4'h9;
    localparam logic [3:0]     CMD_TW        = 4'hC;
    localparam logic [3:0]     CMD_TW_INC2   = 4'hD;
    localparam logic [3:0]     CMD_TW_PROG   = 4'hF;

    localparam logic [7:0]     OP_MOVLW      = 8'h0E;
    localparam logic [7:0]     OP_MOVWF      = 8'h6E;
    localparam logic [3:0]     OP_BSF        = 4'h8;
    localparam logic [3:0]     OP_BCF        = 4'h9;
    localparam logic [7:0]     REG_PTR_U     = 8'hF8;
    localparam logic [7:0]     REG_PTR_H     = 8'hF7;
    localparam logic [7:0]     REG_PTR_L     = 8'hF6;
    localparam logic [7:0]     REG_MEMCTL    = 8'hA6;
    localparam logic [7:0]     MEMCTL_RST    = 8'h00;

    localparam logic [21:0]    BUF_BASE      = 22'h000000;
    localparam logic [21:0]    ID_FIRST      = 22'h200000;
    localparam logic [21:0]    ID_LAST       = 22'h200007;
    localparam logic [21:0]    PTR_STEP_WR   = 22'h000002;
    localparam logic [21:0]    PTR_STEP_RD   = 22'h000001;

    localparam logic [4:0]     CNT_CMD_LAST  = 5'h03;
    localparam logic [4:0]     CNT_PAY_LAST  = 5'h0F;
    localparam logic [4:0]     CNT_BYTE_LAST = 5'h07;
    localparam logic [4:0]     CNT_STEP      = 5'h01;

    typedef enum logic [4:0] {
        ST_CMD     = 5'b00001,
        ST_PAY     = 5'b00010,
        ST_RD_WAIT = 5'b00100,
        ST_RD_OUT  = 5'b01000,
        ST_PROG    = 5'b10000
    } sfp_state_type;

    typedef struct packed {
        logic        active;
        logic        cfg_byte;
        logic [21:0] block_addr;
        logic [7:0]  byte_data;
    } sfp_prog_type;

endpackage : sfp_pkg

/* File: sfp_pin_sync.sv */
`timescale 1ns/10ps
module sfp_pin_sync (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic pin_in,
    output logic      level,
    output logic      rise,
    output logic      fall
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
            last_ff <= sync_ff;
        end
    end

    assign level = sync_ff;
    assign rise  = sync_ff & ~last_ff;
    assign fall  = ~sync_ff & last_ff;

endmodule : sfp_pin_sync

/* File: sfp_serial_prog.sv */
`timescale 1ns/10ps
module sfp_serial_prog #(
    parameter int WBUF_BYTES = sfp_pkg::WBUF_BYTES,
    parameter int IDX_W      = $clog2(WBUF_BYTES)
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 prog_serial_clock,
    input  wire logic                 prog_serial_data_in,
    output logic                      prog_serial_data_out,
    output logic                      prog_serial_data_oe_n,
    output logic [sfp_pkg::PTR_W-1:0] mem_rd_addr,
    input  wire logic [7:0]           mem_rd_data,
    output sfp_pkg::sfp_prog_type     prog_req,
    input  wire logic [IDX_W-1:0]     buf_rd_idx,
    output logic [7:0]                buf_rd_data,
    output logic                      id_region
);

    // ----------------------------------------------------------------
    // Pin sampling
    // ----------------------------------------------------------------
    logic sclk_rise;
    logic sclk_fall;
    logic sdat;

    sfp_pin_sync u_clk_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in (prog_serial_clock),
        .level  (),
        .rise   (sclk_rise),
        .fall   (sclk_fall)
    );

    sfp_pin_sync u_dat_sync (
        .clk    (clk),
        .rst    (rst),
        .pin_in (prog_serial_data_in),
        .level  (sdat),
        .rise   (),
        .fall   ()
    );

    // ----------------------------------------------------------------
    // Storage and decode
    // ----------------------------------------------------------------
    localparam logic [21:0] BLK_MASK = ~(22'(WBUF_BYTES - 1));

    sfp_pkg::sfp_state_type st_ff;
    logic [4:0]             cnt_ff;
    logic [3:0]             cmd_ff;
    logic [15:0]            pay_ff;
    logic [21:0]            ptr_ff;
    logic [7:0]             wreg_ff;
    logic [7:0]             memctl_ff;
    logic                   arm_ff;
    logic [7:0]             out_sr_ff;
    logic                   oe_n_ff;
    logic [7:0]             buf_rd_ff;
    sfp_pkg::sfp_prog_type  prog_ff;
    logic [7:0]             wbuf [WBUF_BYTES];

    logic [3:0]  nxt_cmd;
    logic [15:0] nxt_pay;
    logic        exec;
    logic        is_store;
    logic        code_ok;
    logic        cfg_sel;

    function automatic logic [IDX_W-1:0] buf_idx(input logic [21:0] ptr, input logic hi);
        buf_idx = {ptr[IDX_W-1:1], hi};
    endfunction : buf_idx

    assign nxt_cmd  = {sdat, cmd_ff[3:1]};
    assign nxt_pay  = {sdat, pay_ff[15:1]};
    assign exec     = (st_ff == sfp_pkg::ST_PAY) && sclk_fall && (cnt_ff == sfp_pkg::CNT_PAY_LAST);
    assign is_store = (cmd_ff == sfp_pkg::CMD_TW) || (cmd_ff == sfp_pkg::CMD_TW_INC2)
                   || (cmd_ff == sfp_pkg::CMD_TW_PROG);
    assign cfg_sel  = memctl_ff[sfp_pkg::CFG_SEL_BIT];
    assign code_ok  = memctl_ff[sfp_pkg::CODE_SEL_BIT] && !cfg_sel;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff  <= sfp_pkg::ST_CMD;
            cnt_ff <= 5'h00;
        end else begin
            unique case (st_ff)
                sfp_pkg::ST_CMD: begin
                    // programming held by fourth high clock
                    if (arm_ff && sclk_rise && cnt_ff == sfp_pkg::CNT_CMD_LAST) begin
                        st_ff <= sfp_pkg::ST_PROG;
                    end else if (sclk_fall) begin
                        if (cnt_ff == sfp_pkg::CNT_CMD_LAST) begin
                            cnt_ff <= 5'h00;
                            st_ff  <= (nxt_cmd == sfp_pkg::CMD_RD_INC) ? sfp_pkg::ST_RD_WAIT
                                                                       : sfp_pkg::ST_PAY;
                        end else begin
                            cnt_ff <= cnt_ff + sfp_pkg::CNT_STEP;
                        end
                    end
                end
                sfp_pkg::ST_PROG: begin
                    if (sclk_fall) begin
                        cnt_ff <= 5'h00;
                        st_ff  <= sfp_pkg::ST_PAY;
                    end
                end
                sfp_pkg::ST_PAY: begin
                    if (sclk_fall) begin
                        if (cnt_ff == sfp_pkg::CNT_PAY_LAST) begin
                            cnt_ff <= 5'h00;
                            st_ff  <= sfp_pkg::ST_CMD;
                        end else begin
                            cnt_ff <= cnt_ff + sfp_pkg::CNT_STEP;
                        end
                    end
                end
                sfp_pkg::ST_RD_WAIT, sfp_pkg::ST_RD_OUT: begin
                    if (sclk_fall) begin
                        if (cnt_ff == sfp_pkg::CNT_BYTE_LAST) begin
                            cnt_ff <= 5'h00;
                            st_ff  <= (st_ff == sfp_pkg::ST_RD_WAIT) ? sfp_pkg::ST_RD_OUT
                                                                      : sfp_pkg::ST_CMD;
                        end else begin
                            cnt_ff <= cnt_ff + sfp_pkg::CNT_STEP;
                        end
                    end
                end
                default: begin
                    st_ff  <= sfp_pkg::ST_CMD;
                    cnt_ff <= 5'h00;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Command and payload shifting
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_ff <= 4'h0;
            pay_ff <= 16'h0000;
        end else if (sclk_fall) begin
            if (st_ff == sfp_pkg::ST_CMD || st_ff == sfp_pkg::ST_PROG) begin
                cmd_ff <= nxt_cmd;
            end
            if (st_ff == sfp_pkg::ST_PAY) begin
                pay_ff <= nxt_pay;
            end
        end
    end

    // ----------------------------------------------------------------
    // Core instructions and table pointer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ptr_ff    <= sfp_pkg::BUF_BASE;
            wreg_ff   <= 8'h00;
            memctl_ff <= sfp_pkg::MEMCTL_RST;
        end else if (exec && cmd_ff == sfp_pkg::CMD_CORE) begin
            if (nxt_pay[15:8] == sfp_pkg::OP_MOVLW) begin
                wreg_ff <= nxt_pay[7:0];
            end else if (nxt_pay[15:8] == sfp_pkg::OP_MOVWF) begin
                unique case (nxt_pay[7:0])
                    sfp_pkg::REG_PTR_U:  ptr_ff[21:16] <= wreg_ff[5:0];
                    sfp_pkg::REG_PTR_H:  ptr_ff[15:8]  <= wreg_ff;
                    sfp_pkg::REG_PTR_L:  ptr_ff[7:0]   <= wreg_ff;
                    sfp_pkg::REG_MEMCTL: memctl_ff     <= wreg_ff;
                    default: ;
                endcase
            end else if ((nxt_pay[15:12] == sfp_pkg::OP_BSF || nxt_pay[15:12] == sfp_pkg::OP_BCF)
                         && nxt_pay[7:0] == sfp_pkg::REG_MEMCTL) begin
                memctl_ff[nxt_pay[11:9]] <= (nxt_pay[15:12] == sfp_pkg::OP_BSF);
            end
        end else if (exec && cmd_ff == sfp_pkg::CMD_TW_INC2) begin
            ptr_ff <= ptr_ff + sfp_pkg::PTR_STEP_WR;
        end else if (st_ff == sfp_pkg::ST_RD_WAIT && sclk_fall
                     && cnt_ff == sfp_pkg::CNT_BYTE_LAST) begin
            ptr_ff <= ptr_ff + sfp_pkg::PTR_STEP_RD;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer
    // ----------------------------------------------------------------
    // buffer filled first
    always_ff @(posedge clk) begin
        if (exec && is_store && !cfg_sel) begin
            wbuf[buf_idx(ptr_ff, 1'b0)] <= nxt_pay[7:0];
            wbuf[buf_idx(ptr_ff, 1'b1)] <= nxt_pay[15:8];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            buf_rd_ff <= 8'h00;
        end else begin
            buf_rd_ff <= wbuf[buf_rd_idx];
        end
    end

    // ----------------------------------------------------------------
    // Programming request
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            arm_ff  <= 1'b0;
            prog_ff <= '0;
        end else begin
            if (exec && cmd_ff == sfp_pkg::CMD_TW_PROG) begin
                arm_ff <= code_ok || cfg_sel;
                prog_ff.byte_data <= ptr_ff[0] ? nxt_pay[15:8] : nxt_pay[7:0];
                prog_ff.cfg_byte  <= cfg_sel;
            end
            if (st_ff == sfp_pkg::ST_CMD && arm_ff && sclk_rise
                && cnt_ff == sfp_pkg::CNT_CMD_LAST) begin
                arm_ff <= 1'b0;
                prog_ff.active <= 1'b1;
                prog_ff.block_addr <= prog_ff.cfg_byte ? ptr_ff : (ptr_ff & BLK_MASK);
            end else if (st_ff == sfp_pkg::ST_PROG && sclk_fall) begin
                prog_ff.active <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data out
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_sr_ff <= 8'h00;
            oe_n_ff   <= 1'b1;
        end else if (sclk_fall) begin
            if (st_ff == sfp_pkg::ST_RD_WAIT && cnt_ff == sfp_pkg::CNT_BYTE_LAST) begin
                out_sr_ff <= mem_rd_data;
                oe_n_ff   <= 1'b0;
            end else if (st_ff == sfp_pkg::ST_RD_OUT) begin
                out_sr_ff <= {1'b0, out_sr_ff[7:1]};
                oe_n_ff   <= (cnt_ff == sfp_pkg::CNT_BYTE_LAST);
            end
        end
    end

    assign prog_serial_data_out  = out_sr_ff[0];
    assign prog_serial_data_oe_n = oe_n_ff;
    assign mem_rd_addr           = ptr_ff;
    assign prog_req              = prog_ff;
    assign buf_rd_data           = buf_rd_ff;
    assign id_region = (ptr_ff >= sfp_pkg::ID_FIRST) && (ptr_ff <= sfp_pkg::ID_LAST);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_cmd_done;
        st_ff == sfp_pkg::ST_CMD && sclk_fall && cnt_ff == sfp_pkg::CNT_CMD_LAST;
    endsequence
    sequence s_wait_done;
        st_ff == sfp_pkg::ST_RD_WAIT && sclk_fall && cnt_ff == sfp_pkg::CNT_BYTE_LAST;
    endsequence
    sequence s_pay_done;
        exec;
    endsequence

    cmd_to_read_a: assert property (s_cmd_done ##0 (nxt_cmd == sfp_pkg::CMD_RD_INC)
        |=> st_ff == sfp_pkg::ST_RD_WAIT) else $error("read command not decoded");
    read_inc_a: assert property (s_wait_done |=> ptr_ff == $past(ptr_ff) + 22'h000001)
        else $error("read did not advance pointer");
    read_data_a: assert property (s_wait_done |=> !prog_serial_data_oe_n
        && prog_serial_data_out == $past(mem_rd_data[0])) else $error("read bit wrong");
    read_drive_a: assert property (st_ff == sfp_pkg::ST_RD_OUT |-> !prog_serial_data_oe_n)
        else $error("data pin released during read out");
    inc_two_a: assert property (s_pay_done ##0 (cmd_ff == sfp_pkg::CMD_TW_INC2)
        |=> ptr_ff == $past(ptr_ff) + 22'h000002) else $error("pointer not advanced by two");
    pay_then_cmd_a: assert property (s_pay_done |=> st_ff == sfp_pkg::ST_CMD && cnt_ff == 5'h00)
        else $error("payload did not return to command");
    prog_end_a: assert property (st_ff == sfp_pkg::ST_PROG && sclk_fall
        |=> !prog_req.active && st_ff == sfp_pkg::ST_PAY) else $error("programming not ended");
    prog_block_a: assert property ($rose(prog_req.active) && !prog_req.cfg_byte
        |-> prog_req.block_addr[IDX_W-1:0] == '0
            && prog_req.block_addr[21:IDX_W] == ptr_ff[21:IDX_W])
        else $error("wrong programming block");
    prog_mode_a: assert property ($rose(prog_req.active) && !prog_req.cfg_byte
        |-> $past(code_ok)) else $error("programming without code select");
    cfg_byte_a: assert property (s_pay_done ##0 (cmd_ff == sfp_pkg::CMD_TW_PROG && cfg_sel)
        |=> prog_req.byte_data == ($past(ptr_ff[0]) ? $past(nxt_pay[15:8])
                                                   : $past(nxt_pay[7:0])))
        else $error("wrong configuration byte");

endmodule : sfp_serial_prog

/* File: sfp_prog_model.sv */
`timescale 1ns/10ps
module sfp_prog_model (
    input  wire logic clk,
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    output logic      sclk,
    output wire logic sdata
);
    logic drv_en;
    logic drv_bit;
    logic idle_bit = 1'b0;

    // ---------------------------------------------
    // Data line level
    // ---------------------------------------------
    // Released line wanders every cycle
    always @(posedge clk) idle_bit <= ~idle_bit;
    assign sdata = !dev_oe_n ? dev_out : (drv_en ? drv_bit : idle_bit);

    initial begin
        sclk = 1'b0;
        drv_en = 1'b1;
        drv_bit = 1'b0;
    end

    // ---------------------------------------------
    // Serial frames
    // ---------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic shift(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            drv_en = 1'b1;
            drv_bit = v[i];
            sclk = 1'b1;
            tick(4);
            sclk = 1'b0;
            tick(4);
        end
    endtask : shift

    task automatic frame(input logic [3:0] cmd, input logic [15:0] pay);
        shift({12'h000, cmd}, 4);
        shift(pay, 16);
    endtask : frame

    task automatic core(input logic [15:0] pay);
        frame(4'h0, pay);
    endtask : core

    task automatic set_ptr(input logic [21:0] a);
        core({8'h0E, 2'h0, a[21:16]});
        core(16'h6EF8);
        core({8'h0E, a[15:8]});
        core(16'h6EF7);
        core({8'h0E, a[7:0]});
        core(16'h6EF6);
    endtask : set_ptr

    // line released at the eighth operand fall, clock held low for turnaround
    task automatic read_byte(output logic [7:0] b);
        shift(16'h0009, 4);
        shift(16'h0000, 7);
        sclk = 1'b1;
        tick(4);
        sclk = 1'b0;
        drv_en = 1'b0;
        tick(12);
        for (int i = 0; i < 8; i++) begin
            sclk = 1'b1;
            tick(4);
            b[i] = sdata;
            sclk = 1'b0;
            tick(4);
        end
        tick(4);
        drv_en = 1'b1;
    endtask : read_byte

    // fourth clock of the no-op held high
    task automatic prog_start;
        shift(16'h0000, 3);
        drv_bit = 1'b0;
        sclk = 1'b1;
    endtask : prog_start

    task automatic prog_end(input int p10);
        sclk = 1'b0;
        tick(p10);
        shift(16'h0000, 16);
    endtask : prog_end
endmodule : sfp_prog_model

/* File: test_serial_flash_program_read.sv */
`timescale 1ns/10ps
module test_serial_flash_program_read;
    logic                  clk;
    logic                  rst;
    wire                   sclk;
    wire                   sdata;
    logic                  dout;
    logic                  oe_n;
    logic [21:0]           addr;
    logic [7:0]            mem_data;
    sfp_pkg::sfp_prog_type req;
    logic [2:0]            idx;
    logic [7:0]            buf_data;
    logic                  id_reg;
    int                    miscompares = 0;
    int                    total_checks = 0;

    always #25 clk = ~clk;
    assign mem_data = addr[7:0] ^ addr[21:14];

    sfp_serial_prog #(.WBUF_BYTES(8)) dut_u (
        .clk                   (clk),
        .rst                   (rst),
        .prog_serial_clock     (sclk),
        .prog_serial_data_in   (sdata),
        .prog_serial_data_out  (dout),
        .prog_serial_data_oe_n (oe_n),
        .mem_rd_addr           (addr),
        .mem_rd_data           (mem_data),
        .prog_req              (req),
        .buf_rd_idx            (idx),
        .buf_rd_data           (buf_data),
        .id_region             (id_reg)
    );

    sfp_prog_model prog_u (
        .clk      (clk),
        .dev_out  (dout),
        .dev_oe_n (oe_n),
        .sclk     (sclk),
        .sdata    (sdata)
    );

    // ---------------------------------------------
    // Helpers
    // ---------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : expect_eq

    task automatic conclude;
        $display("checks %0d, miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude

    task automatic prog_window(input logic act, input logic cfg, input logic [21:0] blk,
                               input logic [7:0] byt);
        prog_u.prog_start();
        tick(20);
        expect_eq(req.active, act);
        if (act) begin
            expect_eq(req.cfg_byte, cfg);
            expect_eq(req.block_addr, blk);
            if (cfg)
                expect_eq(req.byte_data, byt);
        end
        prog_u.prog_end(20);
        expect_eq(req.active, 1'b0);
    endtask : prog_window

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic test_reset;
        expect_eq(oe_n, 1'b1);
        expect_eq(dout, 1'b0);
        expect_eq(req, 32'h0000_0000);
        expect_eq(addr, 22'h000000);
        expect_eq(id_reg, 1'b0);
        $display("reset test done");
    endtask : test_reset

    // reads in ID space, top of map, bottom
    task automatic test_read;
        logic [21:0] a;
        logic [7:0]  b;
        logic [21:0] starts [3] = '{22'h200006, 22'h3FFFFE, 22'h000000};
        for (int s = 0; s < 3; s++) begin
            prog_u.set_ptr(starts[s]);
            prog_u.frame(4'h3, 16'hFFFF);
            for (int k = 0; k < 2; k++) begin
                a = starts[s] + 22'(k);
                expect_eq(addr, a);
                expect_eq(id_reg, a >= 22'h200000 && a <= 22'h200007);
                prog_u.read_byte(b);
                expect_eq(b, a[7:0] ^ a[21:14]);
                expect_eq(addr, 22'(a + 22'h000001));
                expect_eq(oe_n, 1'b1);
            end
        end
        $display("read test done");
    endtask : test_read

    // boot and blank ID block writes, then refusal
    task automatic test_prog;
        logic [21:0] bases [2] = '{22'h000010, 22'h200000};
        prog_u.core(16'h8EA6);
        prog_u.core(16'h9CA6);
        for (int b = 0; b < 2; b++) begin
            prog_u.set_ptr(bases[b]);
            for (int k = 0; k < 3; k++) begin
                prog_u.frame(4'hD, {4'hA, 4'(k), 4'h5, 4'(k)});
                expect_eq(addr, 22'(bases[b] + 22'(2 * k + 2)));
            end
            prog_u.frame(4'hF, 16'hA353);
            expect_eq(addr, 22'(bases[b] + 22'h000006));
            expect_eq(id_reg, b == 1);
            prog_window(1'b1, 1'b0, bases[b], 8'h00);
            for (int i = 0; i < 8; i++) begin
                idx = 3'(i);
                tick(2);
                expect_eq(buf_data, {(i % 2 == 1) ? 4'hA : 4'h5, 4'(i / 2)});
            end
        end
        prog_u.core(16'h9EA6);
        prog_u.set_ptr(22'h000020);
        prog_u.frame(4'hC, 16'h1234);
        expect_eq(addr, 22'h000020);
        idx = 3'h0;
        tick(2);
        expect_eq(buf_data, 8'h34);
        prog_u.frame(4'hF, 16'h1234);
        prog_window(1'b0, 1'b0, 22'h000020, 8'h00);
        $display("program test done");
    endtask : test_prog

    // one byte per write, pointer parity picks the half
    task automatic test_cfg;
        prog_u.core(16'h8CA6);
        for (int k = 0; k < 2; k++) begin
            prog_u.set_ptr(22'h300000 + 22'(k));
            prog_u.frame(4'hF, 16'hC33A);
            prog_window(1'b1, 1'b1, 22'h300000 + 22'(k), k ? 8'hC3 : 8'h3A);
        end
        $display("config test done");
    endtask : test_cfg

    // ---------------------------------------------
    // Main sequence and watchdog
    // ---------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        idx = 3'h0;
        repeat (5) @(posedge clk);
        #2;
        rst = 1'b0;
        tick(4);
        test_reset();
        test_read();
        test_prog();
        test_cfg();
        conclude();
    end

    initial begin
        #3000000;
        miscompares++;
        conclude();
    end
endmodule : test_serial_flash_program_read
